//--- common/cas_pkg.sv
/*
  cas_pkg: constants and types of the 8-bit core datapath.
  Assumes one 250 MHz clock, synchronous program and data memories
  that return read data in the cycle after the address is seen.
*/
package cas_pkg;
  localparam int RF_N  = 32;
  localparam int IRQ_N = 8;
  // data space map
  localparam logic [15:0] IO_LO    = 16'h0020;
  localparam logic [15:0] IO_HI    = 16'h005F;
  localparam logic [15:0] FLAGS_DA = 16'h005F;
  localparam logic [15:0] SPL_DA   = 16'h005D;
  localparam logic [15:0] SPH_DA   = 16'h005E;
  // program space
  localparam logic [15:0] BOOT_LO  = 16'h0C00;
  localparam logic [15:0] RST_VEC  = 16'h0000;
  localparam logic [15:0] IRQ_VEC  = 16'h0001;
  localparam logic [15:0] PC_ONE   = 16'h0001;
  localparam logic [15:0] PC_TWO   = 16'h0002;
  // register file corners
  localparam logic [4:0]  PTR_X    = 5'h1A;
  localparam logic [4:0]  PTR_Z    = 5'h1E;
  localparam logic [4:0]  HI_BANK  = 5'h10;
  localparam logic [4:0]  WIDE_LO  = 5'h18;
  localparam logic [4:0]  R_ONE    = 5'h01;
  // register port offsets
  localparam logic [3:0]  RA_FLAGS = 4'h0;
  localparam logic [3:0]  RA_SPL   = 4'h1;
  localparam logic [3:0]  RA_SPH   = 4'h2;
  localparam logic [3:0]  RA_PCL   = 4'h3;
  localparam logic [3:0]  RA_PCH   = 4'h4;

  // status_flags, bit 7 down to bit 0
  typedef struct packed {
    logic i; logic t; logic h; logic s;
    logic v; logic n; logic z; logic c;
  } cas_flags_t;

  // data memory request
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        we;
    logic        re;
  } cas_dreq_t;

  typedef enum logic [3:0] {
    OP_MISC = 4'h0, OP_ADD = 4'h1, OP_ADC  = 4'h2, OP_SUB  = 4'h3,
    OP_AND  = 4'h4, OP_OR  = 4'h5, OP_EOR  = 4'h6, OP_MOV  = 4'h7,
    OP_LDI  = 4'h8, OP_SUBI = 4'h9, OP_IO  = 4'hA, OP_ONE  = 4'hB,
    OP_BIT  = 4'hC, OP_MOVW = 4'hD, OP_MEM = 4'hE, OP_ADIW = 4'hF
  } cas_op_t;

  typedef enum logic [3:0] {
    MS_NOP = 4'h0, MS_SEI = 4'h1, MS_CLI = 4'h2, MS_RETURN_FROM_IRQ = 4'h3,
    MS_RET = 4'h4, MS_LPM = 4'h5, MS_SPM = 4'h6, MS_CALL = 4'h7
  } cas_misc_t;

  typedef enum logic [3:0] {
    U_COM = 4'h0, U_NEG = 4'h1, U_INC = 4'h2, U_DEC = 4'h3,
    U_LSR = 4'h4
  } cas_unop_t;

  typedef enum logic [3:0] {
    ST_EXEC = 4'h0, ST_CALLW = 4'h1, ST_PUSH = 4'h2, ST_POP1 = 4'h3,
    ST_POP2 = 4'h4, ST_POP3  = 4'h5, ST_LD1  = 4'h6, ST_LD2  = 4'h7,
    ST_LPM1 = 4'h8, ST_LPM2  = 4'h9
  } cas_state_t;
endpackage

//--- design/cas_core.sv
/*
  cas_core: fetch/execute datapath, 32x8 register file, ALU and
  status_flags of an 8-bit core, with stack, interrupt entry and
  a plain register port.
  Assumes program and data memories answer one cycle after the
  address; interrupt requests are asynchronous levels.
*/
// Strobed register access and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
module cas_core
  import cas_pkg::*;
(
  // clock and reset
  input  logic             clk,
  input  logic             rstn,
  // program memory
  output logic [15:0]      pmAddr,
  input  logic [15:0]      pmData,
  // data memory
  output cas_dreq_t        dReq,
  input  logic [7:0]       dRdata,
  // self-programming
  output logic             spmWe,
  output logic [15:0]      spmAddr,
  output logic [15:0]      spmData,
  // interrupts
  input  logic [IRQ_N-1:0] irqReq,
  output logic             irqAck,
  output logic [2:0]       irqId,
  // register port
  input  logic [3:0]       regAddr,
  input  logic [7:0]       regWdata,
  input  logic             regWr,
  input  logic             regRd,
  output logic [7:0]       regRdata,
  // status
  output cas_flags_t       flags
);

  cas_state_t       st_q, st_d;
  cas_flags_t       fl_q, fl_d;
  logic [15:0]      fetch_q, fetch_d, exPc_q;
  logic [15:0]      sp_q, sp_d, ret_q, ret_d, tgt_q, tgt_d;
  logic [15:0]      spmA_q, spmA_d, spmD_q, spmD_d;
  logic [7:0]       rf_q [RF_N];
  logic [7:0]       rf_d [RF_N];
  logic [7:0]       hi_q, hi_d, rdat_q, rdat_d;
  logic [4:0]       ldr_q, ldr_d;
  logic [2:0]       id_q, id_d;
  logic             fv_q, fv_d, blk_q, blk_d;
  logic             ack_q, ack_d, spmWe_q, spmWe_d;
  cas_dreq_t        dq_q, dq_d;
  logic [IRQ_N-1:0] irqM_q, irqS_q;
  // write ports and decode
  logic             we0, we1;
  logic [4:0]       wa0, wa1, dst, pb, pi;
  logic [7:0]       wd0, wd1, opA, opB, bx, res, mVal;
  cas_op_t          op;
  cas_misc_t        msc;
  cas_unop_t        uop;
  logic [4:0]       rd, rr;
  logic [7:0]       kImm;
  logic [2:0]       bsel;
  logic             isSub, cinU, ci, cOut, hOut, vOut, zr;
  logic [8:0]       sum9;
  logic [4:0]       nib5;
  logic [16:0]      s17;
  logic [15:0]      wv, mA, zPtr;
  logic             mInt, irqHit, take;
  logic [2:0]       irqIdx;

  // two-flop synchroniser on the asynchronous requests
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irqM_q <= '0;
      irqS_q <= '0;
    end else begin
      irqM_q <= irqReq;
      irqS_q <= irqM_q;
    end
  end

  // word fields, two-word call uses next word
  assign op   = cas_op_t'(pmData[15:12]);
  assign msc  = cas_misc_t'(pmData[3:0]);
  assign uop  = cas_unop_t'(pmData[3:0]);
  assign rd   = pmData[8:4];
  assign rr   = {pmData[9], pmData[3:0]};
  assign kImm = {pmData[11:8], pmData[3:0]};
  assign bsel = pmData[2:0];

  // pointer pairs in the top six registers
  assign pi   = PTR_X + {2'b00, pmData[1:0], 1'b0};
  assign zPtr = {rf_q[PTR_Z + R_ONE], rf_q[PTR_Z]};
  // direct I/O maps onto data space 0x20..0x5F
  assign mA   = (op == OP_IO) ?
                IO_LO + {10'h000, pmData[10:9], pmData[3:0]} :
                {rf_q[pi + R_ONE], rf_q[pi]};
  // first 32 data addresses hit the register file
  assign mInt = (mA < IO_LO) || (mA == FLAGS_DA) ||
                (mA == SPL_DA) || (mA == SPH_DA);
  assign mVal = (mA < IO_LO)    ? rf_q[mA[4:0]] :
                (mA == FLAGS_DA) ? fl_q :
                (mA == SPL_DA)   ? sp_q[7:0] : sp_q[15:8];

  // operand select for two-reg, immediate and single forms
  always_comb begin
    dst   = (op == OP_LDI || op == OP_SUBI) ?
            (HI_BANK | {1'b0, pmData[7:4]}) : rd;
    opA   = rf_q[dst];
    opB   = rf_q[rr];
    isSub = 1'b0;
    cinU  = 1'b0;
    case (op)
      OP_ADC: cinU = fl_q.c;
      OP_SUB: isSub = 1'b1;
      OP_SUBI: begin
        isSub = 1'b1;
        opB   = kImm;
      end
      OP_LDI: opB = kImm;
      OP_ONE: begin
        case (uop)
          U_NEG: begin
            opA   = 8'h00;
            opB   = rf_q[rd];
            isSub = 1'b1;
          end
          U_INC: opB = 8'h01;
          U_DEC: begin
            opB   = 8'h01;
            isSub = 1'b1;
          end
          default: ;
        endcase
      end
      default: ;
    endcase
  end

  // one adder serves add and subtract; borrow is inverted carry
  assign bx   = isSub ? ~opB : opB;
  assign ci   = isSub ^ cinU;
  assign sum9 = {1'b0, opA} + {1'b0, bx} + {8'h00, ci};
  assign nib5 = {1'b0, opA[3:0]} + {1'b0, bx[3:0]} + {4'h0, ci};
  assign hOut = nib5[4] ^ isSub;
  assign vOut = (opA[7] == bx[7]) && (sum9[7] != opA[7]);
  assign cOut = sum9[8] ^ isSub;
  assign pb   = WIDE_LO + {2'b00, pmData[5:4], 1'b0};
  assign wv   = {rf_q[pb + R_ONE], rf_q[pb]};
  assign s17  = {1'b0, wv} + {11'h000, pmData[7:6], pmData[3:0]};

  // logic and shift results
  always_comb begin
    res = sum9[7:0];
    case (op)
      OP_AND: res = opA & opB;
      OP_OR:  res = opA | opB;
      OP_EOR: res = opA ^ opB;
      OP_MOV, OP_LDI: res = opB;
      OP_ONE: begin
        if (uop == U_COM) res = ~opA;
        if (uop == U_LSR) res = {1'b0, opA[7:1]};
      end
      default: ;
    endcase
  end
  assign zr = (res == 8'h00);

  always_comb begin
    irqHit = 1'b0;
    irqIdx = 3'h0;
    for (int k = IRQ_N - 1; k >= 0; k--) begin
      if (irqS_q[k]) begin
        irqHit = 1'b1;
        irqIdx = 3'(k);
      end
    end
  end
  assign take = fl_q.i && irqHit && fv_q && (st_q == ST_EXEC) && !blk_q;

  // sequencer, flags, stack and register port: next values
  always_comb begin
    st_d    = st_q;
    // default keeps fetching one word ahead
    fetch_d = fetch_q + PC_ONE;
    fv_d    = 1'b1;
    fl_d    = fl_q;
    sp_d    = sp_q;
    ret_d   = ret_q;
    tgt_d   = tgt_q;
    hi_d    = hi_q;
    ldr_d   = ldr_q;
    blk_d   = blk_q;
    id_d    = id_q;
    ack_d   = 1'b0;
    dq_d    = '0;
    spmWe_d = 1'b0;
    spmA_d  = spmA_q;
    spmD_d  = spmD_q;
    we0     = 1'b0;
    wa0     = dst;
    wd0     = res;
    we1     = 1'b0;
    wa1     = dst;
    wd1     = 8'h00;
    rdat_d  = 8'h00;
    case (st_q)
      ST_EXEC: begin
        if (take) begin
          fl_d.i  = 1'b0;
          ack_d   = 1'b1;
          id_d    = irqIdx;
          tgt_d   = IRQ_VEC + {13'h0000, irqIdx};
          ret_d   = exPc_q;
          // push low byte; flags stay unsaved
          dq_d    = '{sp_q, exPc_q[7:0], 1'b1, 1'b0};
          sp_d    = sp_q - PC_ONE;
          fetch_d = fetch_q;
          fv_d    = 1'b0;
          st_d    = ST_PUSH;
        end else if (fv_q) begin
          blk_d = 1'b0;
          case (op)
            // two reads, result written same cycle
            OP_ADD, OP_ADC, OP_SUB, OP_SUBI: begin
              we0    = 1'b1;
              fl_d.h = hOut;
              fl_d.v = vOut;
              fl_d.n = res[7];
              fl_d.z = zr;
              fl_d.c = cOut;
            end
            OP_AND, OP_OR, OP_EOR: begin
              we0    = 1'b1;
              fl_d.v = 1'b0;
              fl_d.n = res[7];
              fl_d.z = zr;
            end
            OP_MOV, OP_LDI: we0 = 1'b1;
            OP_ONE: begin
              we0    = 1'b1;
              wa0    = rd;
              fl_d.n = res[7];
              fl_d.z = zr;
              case (uop)
                U_COM: begin
                  fl_d.v = 1'b0;
                  fl_d.c = 1'b1;
                end
                U_NEG: begin
                  fl_d.h = hOut;
                  fl_d.v = vOut;
                  fl_d.c = cOut;
                end
                U_INC, U_DEC: fl_d.v = vOut;
                U_LSR: begin
                  fl_d.c = opA[0];
                  fl_d.n = 1'b0;
                  fl_d.v = opA[0];
                end
                default: we0 = 1'b0;
              endcase
            end
            // bit copy to and from t
            OP_BIT: begin
              if (pmData[9]) begin
                we0 = 1'b1;
                wa0 = rd;
                wd0 = (rf_q[rd] & ~(8'h01 << bsel)) |
                      ({7'h00, fl_q.t} << bsel);
              end else begin
                fl_d.t = rf_q[rd][bsel];
              end
            end
            OP_MOVW: begin
              we0 = 1'b1;
              wa0 = {pmData[7:4], 1'b0};
              wd0 = rf_q[{pmData[3:0], 1'b0}];
              we1 = 1'b1;
              wa1 = {pmData[7:4], 1'b1};
              wd1 = rf_q[{pmData[3:0], 1'b1}];
            end
            OP_ADIW: begin
              we0    = 1'b1;
              wa0    = pb;
              wd0    = s17[7:0];
              we1    = 1'b1;
              wa1    = pb + R_ONE;
              wd1    = s17[15:8];
              fl_d.v = ~wv[15] & s17[15];
              fl_d.n = s17[15];
              fl_d.z = (s17[15:0] == 16'h0000);
              fl_d.c = s17[16];
            end
            OP_IO, OP_MEM: begin
              if (pmData[11]) begin
                if (mA < IO_LO) begin
                  we0 = 1'b1;
                  wa0 = mA[4:0];
                  wd0 = rf_q[rd];
                end else if (mA == FLAGS_DA) fl_d = cas_flags_t'(rf_q[rd]);
                else if (mA == SPL_DA) sp_d[7:0] = rf_q[rd];
                else if (mA == SPH_DA) sp_d[15:8] = rf_q[rd];
                else dq_d = '{mA, rf_q[rd], 1'b1, 1'b0};
              end else if (mInt) begin
                we0 = 1'b1;
                wa0 = rd;
                wd0 = mVal;
              end else begin
                dq_d    = '{mA, 8'h00, 1'b0, 1'b1};
                ldr_d   = rd;
                ret_d   = exPc_q + PC_ONE;
                fetch_d = fetch_q;
                fv_d    = 1'b0;
                st_d    = ST_LD1;
              end
            end
            OP_MISC: begin
              case (msc)
                MS_SEI: fl_d.i = 1'b1;
                MS_CLI: fl_d.i = 1'b0;
                MS_RET, MS_RETURN_FROM_IRQ: begin
                  if (msc == MS_RETURN_FROM_IRQ) begin
                    fl_d.i = 1'b1;
                    blk_d  = 1'b1;
                  end
                  dq_d    = '{sp_q + PC_ONE, 8'h00, 1'b0, 1'b1};
                  sp_d    = sp_q + PC_ONE;
                  fetch_d = fetch_q;
                  fv_d    = 1'b0;
                  st_d    = ST_POP1;
                end
                // table read addressed by the third pointer
                MS_LPM: begin
                  ret_d   = exPc_q + PC_ONE;
                  fetch_d = {1'b0, zPtr[15:1]};
                  fv_d    = 1'b0;
                  st_d    = ST_LPM1;
                end
                // store only honoured from the boot section
                MS_SPM: begin
                  spmWe_d = (exPc_q >= BOOT_LO);
                  spmA_d  = zPtr;
                  spmD_d  = {rf_q[R_ONE], rf_q[0]};
                end
                MS_CALL: begin
                  ret_d = exPc_q + PC_TWO;
                  st_d  = ST_CALLW;
                end
                default: ;
              endcase
            end
            default: ;
          endcase
        end
      end
      ST_CALLW: begin
        tgt_d   = pmData;
        dq_d    = '{sp_q, ret_q[7:0], 1'b1, 1'b0};
        sp_d    = sp_q - PC_ONE;
        fetch_d = fetch_q;
        fv_d    = 1'b0;
        st_d    = ST_PUSH;
      end
      ST_PUSH: begin
        dq_d    = '{sp_q, ret_q[15:8], 1'b1, 1'b0};
        sp_d    = sp_q - PC_ONE;
        fetch_d = tgt_q;
        fv_d    = 1'b0;
        st_d    = ST_EXEC;
      end
      ST_POP1: begin
        dq_d    = '{sp_q + PC_ONE, 8'h00, 1'b0, 1'b1};
        sp_d    = sp_q + PC_ONE;
        fetch_d = fetch_q;
        fv_d    = 1'b0;
        st_d    = ST_POP2;
      end
      ST_POP2: begin
        hi_d    = dRdata;
        fetch_d = fetch_q;
        fv_d    = 1'b0;
        st_d    = ST_POP3;
      end
      ST_POP3: begin
        fetch_d = {hi_q, dRdata};
        fv_d    = 1'b0;
        st_d    = ST_EXEC;
      end
      ST_LD1, ST_LPM1: begin
        fetch_d = fetch_q;
        fv_d    = 1'b0;
        st_d    = (st_q == ST_LD1) ? ST_LD2 : ST_LPM2;
      end
      ST_LD2, ST_LPM2: begin
        we0     = 1'b1;
        wa0     = (st_q == ST_LD2) ? ldr_q : 5'h00;
        wd0     = (st_q == ST_LD2) ? dRdata :
                  (zPtr[0] ? pmData[15:8] : pmData[7:0]);
        fetch_d = ret_q;
        fv_d    = 1'b0;
        st_d    = ST_EXEC;
      end
      default: st_d = ST_EXEC;
    endcase
    // register port: a write here overrides the core this cycle
    if (regWr) begin
      case (regAddr)
        RA_FLAGS: fl_d = cas_flags_t'(regWdata);
        RA_SPL:   sp_d[7:0] = regWdata;
        RA_SPH:   sp_d[15:8] = regWdata;
        default: ;
      endcase
    end
    if (regRd) begin
      case (regAddr)
        RA_FLAGS: rdat_d = fl_q;
        RA_SPL:   rdat_d = sp_q[7:0];
        RA_SPH:   rdat_d = sp_q[15:8];
        RA_PCL:   rdat_d = exPc_q[7:0];
        RA_PCH:   rdat_d = exPc_q[15:8];
        default:  rdat_d = 8'h00;
      endcase
    end
    // sign is derived, never stored on its own
    fl_d.s = fl_d.n ^ fl_d.v;
  end

  // every flag and control flop resets to zero
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q    <= ST_EXEC;
      fl_q    <= '0;
      fetch_q <= RST_VEC;
      exPc_q  <= RST_VEC;
      fv_q    <= 1'b0;
      sp_q    <= '0;
      ret_q   <= '0;
      tgt_q   <= '0;
      hi_q    <= '0;
      ldr_q   <= '0;
      blk_q   <= 1'b0;
      id_q    <= '0;
      ack_q   <= 1'b0;
      dq_q    <= '0;
      spmWe_q <= 1'b0;
      spmA_q  <= '0;
      spmD_q  <= '0;
      rdat_q  <= '0;
    end else begin
      st_q    <= st_d;
      fl_q    <= fl_d;
      fetch_q <= fetch_d;
      exPc_q  <= fetch_q;
      fv_q    <= fv_d;
      sp_q    <= sp_d;
      ret_q   <= ret_d;
      tgt_q   <= tgt_d;
      hi_q    <= hi_d;
      ldr_q   <= ldr_d;
      blk_q   <= blk_d;
      id_q    <= id_d;
      ack_q   <= ack_d;
      dq_q    <= dq_d;
      spmWe_q <= spmWe_d;
      spmA_q  <= spmA_d;
      spmD_q  <= spmD_d;
      rdat_q  <= rdat_d;
    end
  end

  // per-entry write select, port 0 wins a clash
  for (genvar g = 0; g < RF_N; g++) begin : g_rf
    always_comb begin
      rf_d[g] = rf_q[g];
      if (we1 && wa1 == 5'(g)) rf_d[g] = wd1;
      if (we0 && wa0 == 5'(g)) rf_d[g] = wd0;
    end
  end

  // register file storage
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) rf_q <= '{default: 8'h00};
    else rf_q <= rf_d;
  end

  // outputs straight from flops
  assign pmAddr   = fetch_q;
  assign dReq     = dq_q;
  assign spmWe    = spmWe_q;
  assign spmAddr  = spmA_q;
  assign spmData  = spmD_q;
  assign irqAck   = ack_q;
  assign irqId    = id_q;
  assign regRdata = rdat_q;
  assign flags    = fl_q;

  // checks: helper terms read only by assertions
  // reference sums built from the register file, not from the ALU path
  logic       exOk;
  logic [7:0] lowMask;
  logic [7:0] addChk;
  logic [7:0] andChk;
  logic [4:0] nibChk;
  assign exOk    = fv_q && (st_q == ST_EXEC) && !take && !regWr;
  assign lowMask = (8'h01 << id_q) - 8'h01;
  assign addChk  = rf_q[rd] + rf_q[rr];
  assign andChk  = rf_q[rd] & rf_q[rr];
  assign nibChk  = {1'b0, rf_q[rd][3:0]} + {1'b0, rf_q[rr][3:0]};

  a_sign_xor: assert property (@(posedge clk) disable iff (!rstn)
    fl_q.s == (fl_q.n ^ fl_q.v)) else $error("sign not n xor v");
  a_add_onecyc: assert property (@(posedge clk) disable iff (!rstn)
    exOk && op == OP_ADD |=> rf_q[$past(rd)] == $past(addChk))
    else $error("add result not written next cycle");
  a_zero_flag: assert property (@(posedge clk) disable iff (!rstn)
    exOk && op == OP_AND |=> fl_q.z == ($past(andChk) == 8'h00))
    else $error("zero flag wrong after and");
  a_half_carry: assert property (@(posedge clk) disable iff (!rstn)
    exOk && op == OP_ADD |=> fl_q.h == $past(nibChk[4]))
    else $error("half carry wrong after add");
  a_bit_copy: assert property (@(posedge clk) disable iff (!rstn)
    exOk && op == OP_BIT && !pmData[9] |=>
    fl_q.t == $past(rf_q[rd][bsel])) else $error("t copy wrong");
  a_fetch_next: assert property (@(posedge clk) disable iff (!rstn)
    exOk && op == OP_ADD |=> pmAddr == $past(pmAddr) + PC_ONE)
    else $error("fetch stalled on single-cycle op");
  a_irq_push: assert property (@(posedge clk) disable iff (!rstn)
    irqAck |-> dReq.we ##1 dReq.we) else $error("return not pushed");
  a_irq_gate: assert property (@(posedge clk) disable iff (!rstn)
    irqAck |-> $past(fl_q.i)) else $error("irq taken while disabled");
  a_irq_clri: assert property (@(posedge clk) disable iff (!rstn)
    irqAck && !$past(regWr) |-> !fl_q.i) else $error("enable kept");
  a_irq_prio: assert property (@(posedge clk) disable iff (!rstn)
    irqAck |-> ($past(irqS_q) & lowMask) == 8'h00)
    else $error("lower vector was pending");
  a_spm_boot: assert property (@(posedge clk) disable iff (!rstn)
    spmWe |-> $past(exPc_q) >= BOOT_LO) else $error("store from app");

  c_irq: cover property (@(posedge clk) disable iff (!rstn) irqAck);
  c_call: cover property (@(posedge clk) disable iff (!rstn)
    st_q == ST_CALLW ##1 st_q == ST_PUSH);
  c_load: cover property (@(posedge clk) disable iff (!rstn)
    st_q == ST_LD2);
endmodule // cas_core

//--- tb/cas_mem.sv
/*
  cas_mem: program and data memory model beside the core.
  Assumes sync reads: data one cycle after the address is seen.
*/
`timescale 1ns/10ps
module cas_mem
  import cas_pkg::*;
(
  // clock
  input  wire logic        clk,
  // program side
  input  wire logic [15:0] pmAddr,
  output logic      [15:0] pmData,
  // data side
  input  wire cas_dreq_t   dReq,
  output logic      [7:0]  dRdata
);
  logic [15:0] pm [0:1023];
  logic [7:0]  dm [0:1023];

  always @(posedge clk) begin
    pmData <= pm[pmAddr[9:0]];
  end

  // stack writes land in sram; idle read data toggles, not held
  always @(posedge clk) begin
    if (dReq.we) begin
      dm[dReq.addr[9:0]] <= dReq.wdata;
    end
    dRdata <= dReq.re ? dm[dReq.addr[9:0]] : ~dRdata;
  end
endmodule // cas_mem

//--- tb/cas_core_bench.sv
/*
  cas_core_bench: runs a short program, then checks status_flags
  through the register port. Assumes the cas_mem model.
*/
`timescale 1ns/10ps
module cas_core_bench;
  import cas_pkg::*;
  logic             clk;
  logic             rstn;
  logic [15:0]      pmAddr;
  logic [15:0]      pmData;
  cas_dreq_t        dReq;
  logic [7:0]       dRdata;
  logic [3:0]       regAddr;
  logic [7:0]       regWdata;
  logic             regWr;
  logic             regRd;
  logic [7:0]       regRdata;
  cas_flags_t       flags;
  logic [7:0]       irq;
  logic             irqAck;
  logic [2:0]       irqId;
  logic [7:0]       ackCount = 8'h00;
  int               err_count;
  int               total_checks;
  int               cyc;

  cas_core u_dut (.clk(clk), .rstn(rstn), .pmAddr(pmAddr),
    .pmData(pmData), .dReq(dReq), .dRdata(dRdata), .spmWe(),
    .spmAddr(), .spmData(), .irqReq(irq), .irqAck(irqAck), .irqId(irqId),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .flags(flags));
  cas_mem u_mem (.clk(clk), .pmAddr(pmAddr), .pmData(pmData),
    .dReq(dReq), .dRdata(dRdata));

  // 4 ns period
  always #2 clk = ~clk;

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge clk);
    regWr    <= 1'b0;
  endtask

  // data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge clk);
    regRd   <= 1'b0;
    #1 chk(regRdata, exp);
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      err_count++;
      close_out();
    end
  end

  // counts interrupt entries; each should be a one-cycle pulse
  always @(posedge clk) begin
    if (irqAck) begin
      ackCount <= ackCount + 8'h01;
    end
  end

  initial begin
    clk = 0; rstn = 0; regAddr = 0; regWdata = 0; regWr = 0; regRd = 0;
    err_count = 0; total_checks = 0; cyc = 0;
    irq = 8'h00;
    for (int i = 0; i < 1024; i++) u_mem.pm[i] = 16'h0000;
    u_mem.pm[0] = 16'h870F; // r16 = 7F
    u_mem.pm[1] = 16'h8011; // r17 = 01
    u_mem.pm[2] = 16'h1301; // add r16,r17 -> 80
    u_mem.pm[3] = 16'h0001; // set global enable
    u_mem.pm[4] = 16'hC107; // bit 7 of r16 into t
    u_mem.pm[5] = 16'h4310; // and r17,r16 -> 00
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    chk(flags, 8'h00);
    repeat (12) @(posedge clk);
    $display("test reset and program done");
    chk(flags, 8'hE2);
    rd(RA_FLAGS, 8'hE2);
    wr(RA_FLAGS, 8'h00);
    rd(RA_FLAGS, 8'h00);
    wr(RA_FLAGS, 8'hFF);
    rd(RA_FLAGS, 8'hEF);
    wr(RA_SPL, 8'hF0);
    rd(RA_SPL, 8'hF0);
    rd(4'hF, 8'h00);
    $display("test register port done");
    // requests 6 and 7 pending; vector 7 holds a no-op
    wr(RA_FLAGS, 8'h2C);
    @(posedge clk);
    irq <= 8'hC0;
    repeat (8) @(posedge clk);
    chk(ackCount, 8'h00);
    wr(RA_FLAGS, 8'hAC);
    repeat (6) @(posedge clk);
    irq <= 8'h00;
    #1;
    chk(ackCount, 8'h01);
    chk({5'h00, irqId}, 8'h06);
    chk({7'h00, flags.i}, 8'h00);
    rd(RA_FLAGS, 8'h2C);
    rd(RA_SPL, 8'hEE);
    chk(u_mem.dm[16'h00EF], 8'h00);
    $display("test interrupt entry done");
    close_out();
  end
endmodule // cas_core_bench
